/* File: shared/urc_pkg.sv */
// urc_pkg: constants shared by the cell receive port and its fifo.
// assumes: included before any logic/ file that names urc_ types.
package urc_pkg;

	localparam int          URC_BUS_W     = 16; // cell data bus width
	localparam int          URC_ADDR_W    = 5;  // port select width
	localparam int          URC_FIFO_W    = URC_BUS_W + 1; // data + first
	localparam int          URC_FIFO_D    = 16; // fifo depth in words
	localparam int          URC_CNT_W     = 6;  // index within a cell
	localparam int          URC_CELLS_W   = 4;  // complete cells held
	localparam int          URC_LINK_W    = 1 + 1 + URC_ADDR_W;
	// bit positions inside the synchronised link vector
	localparam int          URC_LK_CLK    = 6;
	localparam int          URC_LK_ENB    = 5;
	// cell length: first word plus 26 more, or first byte plus 52
	localparam logic [5:0]  URC_LAST_WIDE = 6'h1A; // index 26
	localparam logic [5:0]  URC_LAST_BYTE = 6'h34; // index 52
	localparam logic [7:0]  URC_HI_ZERO   = 8'h00;
	localparam logic [15:0] URC_BUS_RST   = 16'h0000;
	localparam logic [6:0]  URC_LINK_RST  = 7'h20; // enable high, rest 0

	// state of the output side of the port
	typedef enum logic {URC_IDLE, URC_XFER} urc_state_type;

endpackage : urc_pkg

/* File: logic/urc_fifo.sv */
// urc_fifo: flip-flop fifo, valid/ready on both sides.
// assumes: one clock, asynchronous active-low reset, power-of-two depth.
`timescale 1ns/1ps
module urc_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk,   // system clock
	input  wire logic             rst_n,     // async reset, active low
	input  wire logic [WIDTH-1:0] wr_data,   // word to store
	input  wire logic             wr_valid,  // source offers a word
	output logic                  wr_ready,  // room for a word
	output logic      [WIDTH-1:0] rd_data,   // word at the head
	output logic                  rd_valid,  // head word present
	input  wire logic             rd_ready,  // sink takes the head
	output logic                  full       // every slot in use
);
	import urc_pkg::*;

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [PW-1:0]    wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
	logic [CW-1:0]    cnt_r, cnt_nxt;
	logic             push, pop;

	// handshake is combinational so back-pressure reaches the source at once
	assign full     = (cnt_r == FULL_CNT);
	assign wr_ready = !full;
	assign rd_valid = (cnt_r != '0);
	assign rd_data  = mem_r[rd_ptr_r];
	assign push     = wr_valid && wr_ready;
	assign pop      = rd_valid && rd_ready;

	// next pointers, count and storage
	always_comb begin
		mem_nxt    = mem_r;
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		cnt_nxt    = cnt_r;
		if (push) begin
			mem_nxt[wr_ptr_r] = wr_data;
			wr_ptr_nxt        = wr_ptr_r + PW'(1);
		end
		if (pop)
			rd_ptr_nxt = rd_ptr_r + PW'(1);
		if (push && !pop)
			cnt_nxt = cnt_r + CW'(1);
		else if (pop && !push)
			cnt_nxt = cnt_r - CW'(1);
	end

	// register only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= '0;
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= '0;
		end else begin
			mem_r    <= mem_nxt;
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			cnt_r    <= cnt_nxt;
		end
	end

endmodule : urc_fifo

/* File: logic/urc_rx_port.sv */
// urc_rx_port: receive cell port facing an ATM layer master.
// assumes: link pins are foreign to ref_clk and run well below it;
// the source feeds whole cells, first word flagged, low byte in 8-bit mode.
//
// Overview of operation
// - data bus 16 or 8 bits wide, top bit most significant.
// - bus driven only when enabled and this port selected, else released.
// - parity bit beside every word, odd or even by setting.
// - first flag high exactly with the first word of a cell.
// - master supplies the link clock; outputs change only after its edge.
// - master asserts enable low; word is sampled at end of next cycle.
// - in multi-port use, drivers on only after a cycle with enable low.
// - cell available flag, in multi-port use released to high impedance when not polled.
// - a cell is first word plus 26 words, or first byte plus 52.
`timescale 1ns/1ps
module urc_rx_port #(
	parameter int FIFO_DEPTH = urc_pkg::URC_FIFO_D
) (
	input  wire logic                         ref_clk,   // system clock
	input  wire logic                         rst_n,     // async reset
	input  wire logic                         wide_mode, // 1: 16-bit bus
	input  wire logic                         odd_parity, // 1: odd
	input  wire logic                         multi_phy, // 1: shared bus
	input  wire logic [urc_pkg::URC_ADDR_W-1:0] port_addr, // own address
	input  wire logic [urc_pkg::URC_BUS_W-1:0]  in_data,  // cell word
	input  wire logic                         in_first,  // first of cell
	input  wire logic                         in_valid,  // word offered
	output logic                              in_ready,  // fifo has room
	input  wire logic                         cell_out_clock, // link clock
	input  wire logic                         cell_out_enable_n, // enable
	input  wire logic [urc_pkg::URC_ADDR_W-1:0] cell_out_port_select, // addr
	output logic [urc_pkg::URC_BUS_W-1:0]     cell_out_bus, // data out
	output logic                              cell_out_bus_oe, // drive bus
	output logic                              cell_out_parity, // parity
	output logic                              cell_out_parity_oe, // drive
	output logic                              cell_out_first_flag, // first
	output logic                              cell_out_first_flag_oe, // drv
	output logic                              cell_out_available, // cell
	output logic                              cell_out_available_oe // drv
);
	import urc_pkg::*;

	// upper byte forced to zero in 8-bit mode
	function automatic logic [URC_BUS_W-1:0] fit_word(
		input logic [URC_BUS_W-1:0] d, input logic wide);
		fit_word = wide ? d : {URC_HI_ZERO, d[7:0]};
	endfunction : fit_word

	// ones count of the word made odd or even
	function automatic logic word_parity(
		input logic [URC_BUS_W-1:0] d, input logic wide, input logic odd);
		word_parity = (^fit_word(d, wide)) ^ odd;
	endfunction : word_parity

	function automatic logic [URC_CNT_W-1:0] last_index(input logic wide);
		last_index = wide ? URC_LAST_WIDE : URC_LAST_BYTE;
	endfunction : last_index

	// link pin synchronisers
	logic [URC_LINK_W-1:0] s1_r, s2_r, s3_r, flt_r;
	logic [URC_LINK_W-1:0] s1_nxt, s2_nxt, s3_nxt, flt_nxt;
	logic                  link_rise;
	logic                  enb_now;
	logic [URC_ADDR_W-1:0] addr_now;

	// a bit counts as changed once stages two and three agree
	always_comb begin
		s1_nxt  = {cell_out_clock, cell_out_enable_n, cell_out_port_select};
		s2_nxt  = s1_r;
		s3_nxt  = s2_r;
		flt_nxt = ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & flt_r);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r  <= URC_LINK_RST;
			s2_r  <= URC_LINK_RST;
			s3_r  <= URC_LINK_RST;
			flt_r <= URC_LINK_RST;
		end else begin
			s1_r  <= s1_nxt;
			s2_r  <= s2_nxt;
			s3_r  <= s3_nxt;
			flt_r <= flt_nxt;
		end
	end

	// enable and address seen just before the link edge
	assign link_rise = flt_nxt[URC_LK_CLK] && !flt_r[URC_LK_CLK];
	assign enb_now   = flt_r[URC_LK_ENB];
	assign addr_now  = flt_r[URC_ADDR_W-1:0];

	// fifo in the data path
	logic [URC_FIFO_W-1:0] head;
	logic                  head_valid, fifo_full, rd_take;

	urc_fifo #(
		.WIDTH (URC_FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.wr_data  ({in_first, in_data}),
		.wr_valid (in_valid),
		.wr_ready (in_ready),
		.rd_data  (head),
		.rd_valid (head_valid),
		.rd_ready (rd_take),
		.full     (fifo_full)
	);

	// port state
	urc_state_type         state_r, state_nxt;
	logic [URC_CNT_W-1:0]  in_cnt_r, in_cnt_nxt, out_cnt_r, out_cnt_nxt;
	logic [URC_CELLS_W-1:0] cells_r, cells_nxt;
	logic                  sel_r, sel_nxt, armed_r, armed_nxt;
	logic                  drive_r, drive_nxt, clav_r, clav_nxt;
	logic                  clav_oe_r, clav_oe_nxt, par_r, par_nxt;
	logic                  soc_r, soc_nxt;
	logic [URC_BUS_W-1:0]  bus_r, bus_nxt;
	logic [URC_CNT_W-1:0]  in_idx;
	logic                  accept, in_done, out_done;
	logic                  match, avail, go, flush, head_first;

	assign head_first = head[URC_BUS_W];
	assign accept     = in_valid && in_ready;
	assign in_idx     = in_first ? '0 : in_cnt_r + URC_CNT_W'(1);
	assign in_done    = accept && (in_idx == last_index(wide_mode));
	assign match      = !multi_phy || (addr_now == port_addr);
	// a full fifo headed by a first word also counts: a cell longer
	// than the fifo could otherwise never be offered
	assign avail = (state_r == URC_IDLE)
		? ((cells_r != '0) || (fifo_full && head_first))
		: (cells_r > URC_CELLS_W'(1));
	// stray words with no first word ahead of them are dropped
	assign flush = (state_r == URC_IDLE) && head_valid && !head_first;
	assign go = link_rise && !enb_now && sel_r && head_valid &&
		((state_r == URC_XFER) ||
		 (avail && head_first && (multi_phy || armed_r)));
	assign out_done = go && (state_r == URC_XFER) &&
		(out_cnt_r == last_index(wide_mode));
	assign rd_take  = go || flush;

	// next state, counters and output registers
	always_comb begin
		state_nxt   = state_r;
		in_cnt_nxt  = accept ? in_idx : in_cnt_r;
		out_cnt_nxt = out_cnt_r;
		cells_nxt   = cells_r + URC_CELLS_W'(in_done)
			- URC_CELLS_W'(out_done);
		sel_nxt     = sel_r;
		armed_nxt   = armed_r;
		drive_nxt   = drive_r;
		clav_nxt    = clav_r;
		clav_oe_nxt = clav_oe_r;
		bus_nxt     = bus_r;
		par_nxt     = par_r;
		soc_nxt     = soc_r;
		if (link_rise) begin
			clav_nxt    = avail && match;
			clav_oe_nxt = match;
			if (enb_now) begin
				sel_nxt   = match;
				armed_nxt = 1'b1;
			end
			drive_nxt = !enb_now && sel_r;
			soc_nxt   = 1'b0;
			if (go) begin
				bus_nxt = fit_word(head[URC_BUS_W-1:0], wide_mode);
				par_nxt = word_parity(head[URC_BUS_W-1:0], wide_mode,
					odd_parity);
				if (state_r == URC_IDLE) begin
					soc_nxt     = 1'b1;
					armed_nxt   = 1'b0;
					out_cnt_nxt = URC_CNT_W'(1);
					state_nxt   = URC_XFER;
				end else begin
					out_cnt_nxt = out_cnt_r + URC_CNT_W'(1);
					if (out_done)
						state_nxt = URC_IDLE;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r   <= URC_IDLE;
			in_cnt_r  <= '0;
			out_cnt_r <= '0;
			cells_r   <= '0;
			sel_r     <= 1'b0;
			armed_r   <= 1'b0;
			drive_r   <= 1'b0;
			clav_r    <= 1'b0;
			clav_oe_r <= 1'b0;
			bus_r     <= URC_BUS_RST;
			par_r     <= 1'b0;
			soc_r     <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			in_cnt_r  <= in_cnt_nxt;
			out_cnt_r <= out_cnt_nxt;
			cells_r   <= cells_nxt;
			sel_r     <= sel_nxt;
			armed_r   <= armed_nxt;
			drive_r   <= drive_nxt;
			clav_r    <= clav_nxt;
			clav_oe_r <= clav_oe_nxt;
			bus_r     <= bus_nxt;
			par_r     <= par_nxt;
			soc_r     <= soc_nxt;
		end
	end

	// pins; single-port mode keeps the available flag driven
	assign cell_out_bus           = bus_r;
	assign cell_out_parity        = par_r;
	assign cell_out_first_flag    = soc_r;
	assign cell_out_bus_oe        = drive_r;
	assign cell_out_parity_oe     = drive_r;
	assign cell_out_first_flag_oe = drive_r;
	assign cell_out_available     = clav_r;
	assign cell_out_available_oe  = clav_oe_r || !multi_phy;

	// checks
	a_upper_byte_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!wide_mode && $past(!wide_mode) && cell_out_bus_oe)
		|-> cell_out_bus[15:8] == URC_HI_ZERO)
		else $error("upper byte driven in 8-bit mode");
	a_bus_needs_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(cell_out_bus_oe) |-> $past(link_rise && !enb_now && sel_r))
		else $error("bus driven without enable and selection");
	a_parity_kind: assert property (@(posedge ref_clk) disable iff (!rst_n)
		($changed(cell_out_bus) && $stable(odd_parity) && $stable(wide_mode))
		|-> cell_out_parity == word_parity(cell_out_bus, wide_mode,
			odd_parity))
		else $error("parity does not match data");
	a_first_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(cell_out_first_flag) |-> state_r == URC_XFER
			&& out_cnt_r == URC_CNT_W'(1))
		else $error("first flag not on first word");
	a_edge_update: assert property (@(posedge ref_clk) disable iff (!rst_n)
		($changed(cell_out_bus) || $changed(cell_out_bus_oe)
			|| $changed(cell_out_first_flag)) |-> $past(link_rise))
		else $error("output changed away from link edge");
	a_oe_follows_enb: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(link_rise && enb_now) |=> !cell_out_bus_oe [*2])
		else $error("driver on after enable sampled high");
	a_clav_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(link_rise && multi_phy && addr_now != port_addr)
		|=> !cell_out_available_oe && !cell_out_available)
		else $error("available flag driven for other address");
	a_cell_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(go && state_r == URC_XFER && out_cnt_r == last_index(wide_mode))
		|=> state_r == URC_IDLE ##0 $fell(state_r == URC_XFER))
		else $error("cell not ended after its last word");
	a_clav_has_cell: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(cell_out_available) |-> $past(avail && match))
		else $error("cell available without buffered cell");

endmodule : urc_rx_port

/* File: testbench/urc_atm_master.sv */
// urc_atm_master: behavioural atm layer master on the receive cell link.
// assumes: the bench calls link_cycle; the link clock stands still between.
`timescale 1ns/1ps
module urc_atm_master (
	output logic                          lk_clk,   // link clock
	output logic                          lk_enb_n, // enable, active low
	output logic [urc_pkg::URC_ADDR_W-1:0] lk_addr, // port select
	input  wire logic [urc_pkg::URC_BUS_W-1:0] bus, // data from port
	input  wire logic                     bus_oe,   // data driven
	input  wire logic                     first,    // first of cell
	input  wire logic                     par,      // parity bit
	input  wire logic                     par_oe,   // parity driven
	input  wire logic                     first_oe, // first flag driven
	input  wire logic                     av,       // cell available
	input  wire logic                     av_oe     // available driven
);
	import urc_pkg::*;
	logic [URC_BUS_W-1:0] s_bus;
	logic                 s_oe, s_first, s_par, s_av, s_av_oe;
	logic                 s_par_oe, s_first_oe;
	// idle: clock low, enable high, no port addressed
	initial begin
		lk_clk = 1'b0;
		lk_enb_n = 1'b1;
		lk_addr = 5'h1F;
		s_bus = URC_BUS_RST;
		s_av = 1'b0;
		s_oe = 1'b0;
		s_av_oe = 1'b0;
		s_first = 1'b0;
		s_par = 1'b0;
		s_par_oe = 1'b0;
		s_first_oe = 1'b0;
	end
	// one 320 ns period; odd offset keeps the rising link edge off ref_clk edges
	task automatic link_cycle(input logic enb_n, input logic [4:0] addr);
		#157 lk_clk = 1'b1;
		// a released line shows the inverse of its last value
		s_bus = bus_oe ? bus : ~s_bus;
		s_oe = bus_oe;
		s_first = first_oe ? first : ~s_first;
		s_par = par_oe ? par : ~s_par;
		s_par_oe = par_oe;
		s_first_oe = first_oe;
		s_av = av_oe ? av : ~s_av;
		s_av_oe = av_oe;
		#1 lk_enb_n = enb_n;
		lk_addr = addr;
		#162 lk_clk = 1'b0;
	endtask : link_cycle
endmodule : urc_atm_master

/* File: testbench/test_urc_rx_port.sv */
// test_urc_rx_port: self-checking bench for the receive cell port.
// assumes: urc_pkg compiled first; partner model in urc_atm_master.
`timescale 1ns/1ps
module test_urc_rx_port;
	import urc_pkg::*;
	logic                  ref_clk, rst_n, wide_mode, odd_parity, multi_phy;
	logic [URC_ADDR_W-1:0] port_addr, lk_addr;
	logic [URC_BUS_W-1:0]  in_data, o_bus;
	logic                  in_first, in_valid, in_ready, lk_clk, lk_enb_n;
	logic                  o_oe, o_par, o_par_oe, o_first, o_first_oe;
	logic                  o_av, o_av_oe;
	int                    failures, checked, cycles;

	urc_rx_port u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.wide_mode(wide_mode), .odd_parity(odd_parity),
		.multi_phy(multi_phy), .port_addr(port_addr), .in_data(in_data),
		.in_first(in_first), .in_valid(in_valid), .in_ready(in_ready),
		.cell_out_clock(lk_clk), .cell_out_enable_n(lk_enb_n),
		.cell_out_port_select(lk_addr), .cell_out_bus(o_bus),
		.cell_out_bus_oe(o_oe), .cell_out_parity(o_par),
		.cell_out_parity_oe(o_par_oe), .cell_out_first_flag(o_first),
		.cell_out_first_flag_oe(o_first_oe), .cell_out_available(o_av),
		.cell_out_available_oe(o_av_oe));
	urc_atm_master u_atm (.lk_clk(lk_clk), .lk_enb_n(lk_enb_n),
		.lk_addr(lk_addr), .bus(o_bus), .bus_oe(o_oe), .first(o_first),
		.par(o_par), .par_oe(o_par_oe), .first_oe(o_first_oe),
		.av(o_av), .av_oe(o_av_oe));

	// 25 MHz system clock
	initial ref_clk = 1'b0;
	always #20 ref_clk = ~ref_clk;
	// runaway guard, far above the roughly 800 cycles the tests need
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict

	task automatic check_bit(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask : check_bit

	task automatic check_word(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : check_word

	// upper byte is junk in byte mode so a leak onto the bus shows
	function automatic logic [15:0] word_of(input int i, input logic wide);
		return wide ? 16'hC300 + 16'(i) * 16'h0111 : {8'h5A, 8'h40 + 8'(i)};
	endfunction : word_of

	// source side: one word per accepted edge, called just after posedge
	task automatic feed(input int n);
		logic got;
		for (int i = 0; i < n; i++) begin
			in_valid <= 1'b1;
			in_first <= (i == 0);
			in_data <= word_of(i, wide_mode);
			do begin
				@(negedge ref_clk);
				got = in_ready;
				@(posedge ref_clk);
			end while (got !== 1'b1);
		end
		in_valid <= 1'b0;
		in_first <= 1'b0;
	endtask : feed

	task automatic wait_full();
		for (int i = 0; i < 200 && in_ready !== 1'b0; i++) @(negedge ref_clk);
		check_bit("in_ready when full", 1'b0, in_ready);
	endtask : wait_full

	// select, then n enabled cycles; word k is seen one link cycle later
	task automatic read_cell(input int n, input logic [4:0] a);
		logic [15:0] w;
		u_atm.link_cycle(1'b1, a);
		u_atm.link_cycle(1'b0, a);
		u_atm.link_cycle(1'b0, a);
		check_bit("available", 1'b1, u_atm.s_av);
		for (int k = 0; k < n; k++) begin
			w = word_of(k, wide_mode);
			if (!wide_mode) w[15:8] = URC_HI_ZERO;
			u_atm.link_cycle(k > n - 3, a);
			check_word("bus", w, u_atm.s_bus);
			check_bit("first flag", k == 0, u_atm.s_first);
			check_bit("parity", odd_parity ? ~^w : ^w, u_atm.s_par);
			check_bit("driving", 1'b1, u_atm.s_oe);
			check_bit("par drive", 1'b1, u_atm.s_par_oe);
			check_bit("flag drive", 1'b1, u_atm.s_first_oe);
		end
		u_atm.link_cycle(1'b1, a);
		check_bit("released", 1'b0, u_atm.s_oe);
		check_bit("par released", 1'b0, u_atm.s_par_oe);
		check_bit("flag released", 1'b0, u_atm.s_first_oe);
		check_bit("no further cell", 1'b0, u_atm.s_av);
	endtask : read_cell

	task automatic t_reset();
		@(negedge ref_clk);
		check_bit("reset in_ready", 1'b1, in_ready);
		check_bit("reset bus drive", 1'b0, o_oe);
		check_bit("reset avail drive", 1'b0, o_av_oe);
		@(posedge ref_clk);
		$display("test reset done");
	endtask : t_reset

	// full fifo holds part of a cell; a foreign address must get nothing
	task automatic t_wide();
		fork
			feed(27);
		join_none
		wait_full();
		u_atm.link_cycle(1'b1, 5'h0C);
		u_atm.link_cycle(1'b0, 5'h0C);
		u_atm.link_cycle(1'b0, 5'h0C);
		check_bit("foreign avail", 1'b0, u_atm.s_av & u_atm.s_av_oe);
		check_bit("foreign avail drive", 1'b0, u_atm.s_av_oe);
		u_atm.link_cycle(1'b1, 5'h0C);
		check_bit("foreign drive", 1'b0, u_atm.s_oe);
		read_cell(27, 5'h13);
		wait fork;
		@(negedge ref_clk);
		check_bit("drained", 1'b1, in_ready);
		$display("test wide_cell done");
	endtask : t_wide

	// second reset into single-port byte mode with odd parity
	task automatic t_byte();
		@(posedge ref_clk);
		rst_n <= 1'b0;
		wide_mode <= 1'b0;
		odd_parity <= 1'b1;
		multi_phy <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		fork
			feed(53);
		join_none
		wait_full();
		read_cell(53, 5'h00);
		check_bit("single avail drive", 1'b1, u_atm.s_av_oe);
		wait fork;
		$display("test byte_cell done");
	endtask : t_byte

	initial begin
		failures = 0;
		checked = 0;
		cycles = 0;
		rst_n = 1'b0;
		wide_mode = 1'b1;
		odd_parity = 1'b0;
		multi_phy = 1'b1;
		port_addr = 5'h13;
		in_data = URC_BUS_RST;
		in_first = 1'b0;
		in_valid = 1'b0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_reset();
		t_wide();
		t_byte();
		print_verdict();
	end
endmodule : test_urc_rx_port
